// ==== inc/cde_pkg.sv ====
// Constants, types and expansion functions of the colour depth table
package cde_pkg;

    // Component, table and FIFO geometry
    localparam int        COMP_W      = 6;
    localparam int        PIX_W       = 18;
    localparam int        TABLE_DEPTH = 128;
    localparam int        INDEX_W     = 7;
    localparam int        FIFO_DEPTH  = 32;
    localparam int        LEVEL_W     = 6;

    // Zero-based entry positions of each colour section
    localparam logic [6:0] RED_BASE   = 7'h00;
    localparam logic [6:0] GREEN_BASE = 7'h20;
    localparam logic [6:0] BLUE_BASE  = 7'h60;
    localparam logic [6:0] LAST_POS   = 7'h7f;

    // Slack kept in the FIFO for pixels already in flight
    localparam logic [6:0] FIFO_SLACK = 7'h03;

    // Pixel depth selection
    typedef enum logic [1:0]
    {
        CDE_MODE_18 = 2'h0,
        CDE_MODE_16 = 2'h1,
        CDE_MODE_12 = 2'h2
    } cde_mode_e;

    // Load sequencer states
    typedef enum logic [1:0]
    {
        CDE_IDLE = 2'b01,
        CDE_LOAD = 2'b10
    } cde_state_e;

    // Default for a 5-bit code: shift left, append the top bit
    function automatic logic [5:0] cde_exp5(input logic [4:0] code);
        cde_exp5 = {code, code[4]};
    endfunction

    // Default for a 4-bit code: append the two top bits
    function automatic logic [5:0] cde_exp4(input logic [3:0] code);
        cde_exp4 = {code, code[3:2]};
    endfunction

endpackage

// ==== hdl/cde_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module cde_fifo
    import cde_pkg::*;
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       srst,
    // Filling side
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // Draining side
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    // Occupancy
    output logic [$clog2(DEPTH):0]          level
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             push;
    logic             pop;

    // Handshake terms
    assign in_ready  = (count_reg != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];
    assign level     = count_reg;

    // Storage write
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

// ==== hdl/cde_table.sv ====
// Programmable 128-entry expansion table with per-entry written flags
`timescale 1ns/1ps
module cde_table
    import cde_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               srst,
    // Write port
    input  wire logic               wr_en,
    input  wire logic [INDEX_W-1:0] wr_index,
    input  wire logic [COMP_W-1:0]  wr_data,
    // Read ports, red, green, blue
    input  wire logic [INDEX_W-1:0] rd_index [3],
    output logic [COMP_W-1:0]       rd_data  [3],
    output logic                    rd_set   [3]
);

    logic [COMP_W-1:0] entry_reg [TABLE_DEPTH];
    logic              set_reg   [TABLE_DEPTH];

    // Hardware reset reloads the defaults and forgets host writes
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            for (int i = 0; i < TABLE_DEPTH; i++)
            begin
                set_reg[i] <= 1'b0;
                if (i < 32)
                begin
                    entry_reg[i] <= cde_exp5(5'(i));
                end
                else if (i < 96)
                begin
                    entry_reg[i] <= 6'(i - 32);
                end
                else
                begin
                    entry_reg[i] <= cde_exp5(5'(i - 96));
                end
            end
        end
        else if (wr_en)
        begin
            entry_reg[wr_index] <= wr_data;
            set_reg[wr_index]   <= 1'b1;
        end
    end

    // Three read ports
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_rd
            assign rd_data[g] = entry_reg[rd_index[g]];
            assign rd_set[g]  = set_reg[rd_index[g]];
        end
    endgenerate

endmodule

// ==== hdl/cde_lut.sv ====
// Colour depth expansion stage between host pixels and frame memory
`timescale 1ns/1ps

// Notes on behaviour
// - 16-bit mode: 5-bit red and blue expand to 6 bits by table.
// - Red section holds 32 entries, load positions 1..32, index by red.
// - Green section holds 64 entries, positions 33..96, index by green.
// - Blue section holds 32 entries, positions 97..128, index by blue.
// - Hardware reset puts every entry back to its default.
// - Red defaults for 00000..01111: shift left, append zero.
// - Red defaults for 10000..11111: shift left, append one.
// - Green defaults equal the green code unchanged.
// - Blue defaults follow red: shift left, append the top bit.
// - 12-bit mode: 4-bit red uses positions 1..16 only.
// - 12-bit default: input followed by its two top bits.
// - 12-bit input 0100 gives default 010001.
// - 12-bit green uses 33..48, blue 97..112, same default pattern.
// - Software reset leaves the table untouched.
module cde_lut
    import cde_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic              soft_reset,
    // Pixel depth selection
    input  wire logic [1:0]        pixel_mode,
    // Host pixel stream
    input  wire logic              pix_valid,
    output logic                   pix_ready_reg,
    input  wire logic [COMP_W-1:0] pix_red,
    input  wire logic [COMP_W-1:0] pix_green,
    input  wire logic [COMP_W-1:0] pix_blue,
    // Table load stream
    input  wire logic              color_table_load_command,
    input  wire logic              param_valid,
    input  wire logic [COMP_W-1:0] param_data,
    output logic                   load_busy_reg,
    output logic                   load_done_reg,
    output logic                   param_ignored_reg,
    // Frame memory write stream
    output logic                   fm_valid_reg,
    input  wire logic              fm_ready,
    output logic [COMP_W-1:0]      fm_red_reg,
    output logic [COMP_W-1:0]      fm_green_reg,
    output logic [COMP_W-1:0]      fm_blue_reg
);

    cde_state_e           state_reg;
    logic [INDEX_W-1:0]   pos_reg;
    logic                 tbl_wr;
    logic [INDEX_W-1:0]   rd_index [3];
    logic [COMP_W-1:0]    rd_data  [3];
    logic                 rd_set   [3];
    logic [COMP_W-1:0]    exp_red;
    logic [COMP_W-1:0]    exp_green;
    logic [COMP_W-1:0]    exp_blue;
    logic                 accept;
    logic                 stage_valid_reg;
    logic [PIX_W-1:0]     stage_data_reg;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 fifo_pop;
    logic [PIX_W-1:0]     fifo_out_data;
    logic [LEVEL_W-1:0]   fifo_level;
    logic                 stage_push;

    // Stored entry wins once the host wrote it, else the mode default
    function automatic logic [5:0] pick(input logic       set,
                                        input logic [5:0] stored,
                                        input logic [5:0] dflt);
        pick = set ? stored : dflt;
    endfunction

    // Load writes go to the position counted in the sequence;
    // a command in the same cycle wins and the parameter is dropped
    assign tbl_wr = param_valid && !color_table_load_command &&
                    (state_reg == CDE_LOAD);

    // Table storage
    cde_table u_table
    (
        .clock    (clock),
        .srst     (srst),
        .wr_en    (tbl_wr),
        .wr_index (pos_reg),
        .wr_data  (param_data),
        .rd_index (rd_index),
        .rd_data  (rd_data),
        .rd_set   (rd_set)
    );

    // Load sequencer; software reset only aborts a running load
    always_ff @(posedge clock)
    begin
        if (srst || soft_reset)
        begin
            state_reg         <= CDE_IDLE;
            pos_reg           <= '0;
            load_done_reg     <= 1'b0;
            param_ignored_reg <= 1'b0;
        end
        else
        begin
            load_done_reg     <= 1'b0;
            param_ignored_reg <= 1'b0;
            case (state_reg)
                CDE_IDLE:
                begin
                    if (param_valid && !color_table_load_command)
                    begin
                        param_ignored_reg <= 1'b1;
                    end
                end
                CDE_LOAD:
                begin
                    if (param_valid && !color_table_load_command)
                    begin
                        pos_reg <= pos_reg + 1'b1;
                        if (pos_reg == LAST_POS)
                        begin
                            state_reg     <= CDE_IDLE;
                            load_done_reg <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_reg <= CDE_IDLE;
                end
            endcase
            if (color_table_load_command)
            begin
                state_reg <= CDE_LOAD;
                pos_reg   <= '0;
            end
        end
    end

    // Busy flag mirrors the sequencer state
    always_ff @(posedge clock)
    begin
        if (srst || soft_reset)
        begin
            load_busy_reg <= 1'b0;
        end
        else if (color_table_load_command)
        begin
            load_busy_reg <= 1'b1;
        end
        else if (state_reg == CDE_LOAD && param_valid &&
                 pos_reg == LAST_POS)
        begin
            load_busy_reg <= 1'b0;
        end
    end

    // Table indices for the incoming pixel
    always_comb
    begin
        rd_index[0] = RED_BASE;
        rd_index[1] = GREEN_BASE;
        rd_index[2] = BLUE_BASE;
        case (cde_mode_e'(pixel_mode))
            CDE_MODE_16:
            begin
                rd_index[0] = RED_BASE + {2'h0, pix_red[4:0]};
                rd_index[1] = GREEN_BASE + {1'h0, pix_green};
                rd_index[2] = BLUE_BASE + {2'h0, pix_blue[4:0]};
            end
            CDE_MODE_12:
            begin
                rd_index[0] = RED_BASE + {3'h0, pix_red[3:0]};
                rd_index[1] = GREEN_BASE + {3'h0, pix_green[3:0]};
                rd_index[2] = BLUE_BASE + {3'h0, pix_blue[3:0]};
            end
            default:
            begin
                rd_index[0] = RED_BASE;
            end
        endcase
    end

    // Expansion of each component
    always_comb
    begin
        exp_red   = pix_red;
        exp_green = pix_green;
        exp_blue  = pix_blue;
        case (cde_mode_e'(pixel_mode))
            CDE_MODE_16:
            begin
                // Top bit appended covers both halves of the range
                exp_red   = pick(rd_set[0], rd_data[0],
                                 cde_exp5(pix_red[4:0]));
                exp_green = pick(rd_set[1], rd_data[1],
                                 pix_green);
                exp_blue  = pick(rd_set[2], rd_data[2],
                                 cde_exp5(pix_blue[4:0]));
            end
            CDE_MODE_12:
            begin
                // 0100 gives 010001, 1100 gives 110011
                exp_red   = pick(rd_set[0], rd_data[0],
                                 cde_exp4(pix_red[3:0]));
                exp_green = pick(rd_set[1], rd_data[1],
                                 cde_exp4(pix_green[3:0]));
                exp_blue  = pick(rd_set[2], rd_data[2],
                                 cde_exp4(pix_blue[3:0]));
            end
            default:
            begin
                exp_red   = pix_red;
                exp_green = pix_green;
                exp_blue  = pix_blue;
            end
        endcase
    end

    // Pixel handshake and stage push
    assign accept     = pix_valid && pix_ready_reg;
    assign stage_push = stage_valid_reg && fifo_in_ready;

    // Ready is registered, so keep room for pixels already in flight
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pix_ready_reg <= 1'b0;
        end
        else
        begin
            pix_ready_reg <= ({1'b0, fifo_level} + FIFO_SLACK) <=
                             7'(FIFO_DEPTH);
        end
    end

    // Expansion stage register; table defaults hold from reset
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            stage_valid_reg <= 1'b0;
            stage_data_reg  <= '0;
        end
        else if (accept)
        begin
            stage_valid_reg <= 1'b1;
            stage_data_reg  <= {exp_red, exp_green, exp_blue};
        end
        else if (stage_push)
        begin
            stage_valid_reg <= 1'b0;
        end
    end

    // Buffer between expansion and frame memory
    cde_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (stage_valid_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (stage_data_reg),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // Output register refills whenever it is empty or being taken
    assign fifo_pop = fifo_out_valid && (!fm_valid_reg || fm_ready);

    // Frame memory write word
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            fm_valid_reg <= 1'b0;
            fm_red_reg   <= '0;
            fm_green_reg <= '0;
            fm_blue_reg  <= '0;
        end
        else if (fifo_pop)
        begin
            fm_valid_reg <= 1'b1;
            fm_red_reg   <= fifo_out_data[17:12];
            fm_green_reg <= fifo_out_data[11:6];
            fm_blue_reg  <= fifo_out_data[5:0];
        end
        else if (fm_ready)
        begin
            fm_valid_reg <= 1'b0;
        end
    end

endmodule

// ==== test/cde_lut_sva.sv ====
// Protocol checker for the colour depth expansion stage
`timescale 1ns/1ps
module cde_lut_chk
    import cde_pkg::*;
(
    // Clock and resets
    input wire logic              clock,
    input wire logic              srst,
    input wire logic              soft_reset,
    // Requests
    input wire logic              pix_valid,
    input wire logic              color_table_load_command,
    input wire logic              param_valid,
    input wire logic              fm_ready,
    // Observed outputs
    input wire logic              pix_ready_reg,
    input wire logic              load_busy_reg,
    input wire logic              load_done_reg,
    input wire logic              param_ignored_reg,
    input wire logic              fm_valid_reg,
    input wire logic [COMP_W-1:0] fm_red_reg,
    input wire logic [COMP_W-1:0] fm_green_reg,
    input wire logic [COMP_W-1:0] fm_blue_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    logic [6:0] inflight_reg;

    // Pixels taken but not yet handed to frame memory
    always_ff @(posedge clock)
    begin
        if (srst)
            inflight_reg <= 7'h00;
        else
            inflight_reg <= inflight_reg + 7'(pix_valid && pix_ready_reg)
                            - 7'(fm_valid_reg && fm_ready);
    end

    // Pixel entering an empty pipe, then emerging
    sequence s_take_idle;
        pix_valid && pix_ready_reg && inflight_reg == 7'h00;
    endsequence
    sequence s_emerge;
        !fm_valid_reg [*2] ##[1:4] fm_valid_reg;
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0) srst |=>
        !fm_valid_reg && !pix_ready_reg && !load_busy_reg)
        else $error("outputs active after reset");
    a_word_holds: assert property (fm_valid_reg && !fm_ready |=>
        fm_valid_reg && $stable({fm_red_reg, fm_green_reg, fm_blue_reg}))
        else $error("word changed while stalled");
    a_word_owned: assert property (fm_valid_reg |-> inflight_reg != 0)
        else $error("word without a pixel");
    a_pixel_emerges: assert property (s_take_idle |=> s_emerge)
        else $error("pixel latency wrong");
    a_busy_rises: assert property (
        color_table_load_command && !soft_reset |=> load_busy_reg)
        else $error("load not started");
    a_done_once: assert property (load_done_reg |=> !load_done_reg)
        else $error("done longer than a cycle");
    a_done_ends: assert property (
        load_done_reg |-> !load_busy_reg && $past(load_busy_reg))
        else $error("done without a load");
    a_busy_holds: assert property (load_busy_reg && !soft_reset &&
        !color_table_load_command && !param_valid |=> load_busy_reg)
        else $error("load ended without parameter");
    a_idle_ignores: assert property (param_valid && !load_busy_reg &&
        !color_table_load_command && !soft_reset &&
        !$past(color_table_load_command) |=> param_ignored_reg)
        else $error("idle parameter not flagged");
endmodule

bind cde_lut cde_lut_chk u_chk (.clock(clock), .srst(srst),
    .soft_reset(soft_reset), .pix_valid(pix_valid),
    .color_table_load_command(color_table_load_command),
    .param_valid(param_valid), .fm_ready(fm_ready),
    .pix_ready_reg(pix_ready_reg), .load_busy_reg(load_busy_reg),
    .load_done_reg(load_done_reg), .param_ignored_reg(param_ignored_reg),
    .fm_valid_reg(fm_valid_reg), .fm_red_reg(fm_red_reg),
    .fm_green_reg(fm_green_reg), .fm_blue_reg(fm_blue_reg));

// ==== test/cde_fm_sink.sv ====
// Frame memory side model taking expanded words, promptly or slowly
`timescale 1ns/1ps
module cde_fm_sink
    import cde_pkg::*;
(
    // Clock, reset and pacing
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic              slow,
    // Frame memory write stream
    input  wire logic              fm_valid_reg,
    input  wire logic [COMP_W-1:0] fm_red_reg,
    input  wire logic [COMP_W-1:0] fm_green_reg,
    input  wire logic [COMP_W-1:0] fm_blue_reg,
    output logic                   fm_ready
);
    logic [1:0]       phase_reg;
    logic [PIX_W-1:0] got [$];

    // Accepts one word in four when slow, so the FIFO backs up
    always_ff @(posedge clock)
    begin
        phase_reg <= srst ? 2'h0 : phase_reg + 2'h1;
        fm_ready  <= !srst && (!slow || phase_reg == 2'h0);
    end

    // Keeps every word taken, in order; the bench pops from it too
    always @(posedge clock)
    begin
        if (!srst && fm_valid_reg && fm_ready)
            got.push_back({fm_red_reg, fm_green_reg, fm_blue_reg});
    end
endmodule

// ==== test/cde_lut_tb.sv ====
// Self-checking bench for the colour depth expansion stage
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        n_checks++; \
        if ((a) !== (e)) \
        begin \
            mismatches++; \
            $display("unexpected at %0t: %h vs %h", $time, a, e); \
        end \
    end
module cde_lut_tb
    import cde_pkg::*;
;
    logic        clock = 0, srst = 1, soft_reset = 0, slow = 0;
    logic        pix_valid = 0, param_valid = 0;
    logic        color_table_load_command = 0;
    logic [1:0]  pixel_mode = 2'h1;
    logic [5:0]  pix_red = 0, pix_green = 0, pix_blue = 0, param_data = 0;
    logic        pix_ready_reg, load_busy_reg, load_done_reg;
    logic        param_ignored_reg, fm_valid_reg, fm_ready;
    logic [5:0]  fm_red_reg, fm_green_reg, fm_blue_reg;
    int          mismatches = 0, n_checks = 0, cycles = 0;
    logic [5:0]  tbl [128];
    bit          wr [128];
    logic [17:0] exp_q [$];

    always #50 clock = ~clock;

    cde_lut uut (.clock(clock), .srst(srst), .soft_reset(soft_reset),
        .pixel_mode(pixel_mode), .pix_valid(pix_valid),
        .pix_ready_reg(pix_ready_reg), .pix_red(pix_red),
        .pix_green(pix_green), .pix_blue(pix_blue),
        .color_table_load_command(color_table_load_command),
        .param_valid(param_valid), .param_data(param_data),
        .load_busy_reg(load_busy_reg), .load_done_reg(load_done_reg),
        .param_ignored_reg(param_ignored_reg), .fm_valid_reg(fm_valid_reg),
        .fm_ready(fm_ready), .fm_red_reg(fm_red_reg),
        .fm_green_reg(fm_green_reg), .fm_blue_reg(fm_blue_reg));

    cde_fm_sink sink (.clock(clock), .srst(srst), .slow(slow),
        .fm_valid_reg(fm_valid_reg), .fm_red_reg(fm_red_reg),
        .fm_green_reg(fm_green_reg), .fm_blue_reg(fm_blue_reg),
        .fm_ready(fm_ready));

    // Cuts a hang short
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // Stored entry once loaded, otherwise the mode default
    function automatic logic [5:0] lk(int idx, logic [5:0] dflt);
        return wr[idx] ? tbl[idx] : dflt;
    endfunction

    // Expected frame memory word for one pixel
    function automatic logic [17:0] ex(logic [1:0] m, logic [5:0] r, g, b);
        case (m)
            2'h1: return {lk(r[4:0], {r[4:0], r[4]}), lk(32 + g, g),
                          lk(96 + b[4:0], {b[4:0], b[4]})};
            2'h2: return {lk(r[3:0], {r[3:0], r[3:2]}),
                          lk(32 + g[3:0], {g[3:0], g[3:2]}),
                          lk(96 + b[3:0], {b[3:0], b[3:2]})};
            default: return {r, g, b};
        endcase
    endfunction

    // Sends 64 pixels covering every code, then compares all words
    task automatic pass(logic [1:0] m);
        logic [17:0] g, e;
        pixel_mode = m;
        pix_valid = 1;
        for (int i = 0; i < 64; i++)
        begin
            pix_red = 6'(i);
            pix_green = 6'(63 - i);
            pix_blue = 6'(i ^ 21);
            exp_q.push_back(ex(m, pix_red, pix_green, pix_blue));
            while (pix_ready_reg !== 1'h1)
                @(negedge clock);
            @(negedge clock);
        end
        pix_valid = 0;
        for (int i = 0; i < 3000 && sink.got.size() < 64; i++)
            @(negedge clock);
        `CHK(sink.got.size(), 64)
        while (exp_q.size() > 0 && sink.got.size() > 0)
        begin
            g = sink.got.pop_front();
            e = exp_q.pop_front();
            `CHK(g, e)
        end
        exp_q.delete();
    endtask

    // Loads n parameters after a command, mirroring them in tbl
    task automatic load(int n, int mul);
        color_table_load_command = 1;
        @(negedge clock);
        color_table_load_command = 0;
        `CHK(load_busy_reg, 1'h1)
        param_valid = 1;
        for (int k = 0; k < n; k++)
        begin
            param_data = 6'(k * mul + 5);
            tbl[k] = param_data;
            wr[k] = 1;
            @(negedge clock);
        end
        param_valid = 0;
    endtask

    // Defaults in every pixel mode, 16-bit under back-pressure
    task automatic t_defaults;
        slow = 1;
        pass(2'h1);
        slow = 0;
        pass(2'h2);
        pass(2'h0);
        pass(2'h3);
    endtask

    // Full 128-entry load, then lookups in both narrow modes
    task automatic t_full_load;
        load(128, 7);
        for (int i = 0; i < 3 && load_done_reg !== 1'h1; i++)
            @(negedge clock);
        `CHK(load_done_reg, 1'h1)
        `CHK(load_busy_reg, 1'h0)
        @(negedge clock);
        `CHK(load_done_reg, 1'h0)
        pass(2'h1);
        pass(2'h2);
    endtask

    // Load aborted by software reset keeps the table
    task automatic t_abort;
        load(10, 3);
        @(negedge clock);
        `CHK(load_busy_reg, 1'h1)
        soft_reset = 1;
        @(negedge clock);
        soft_reset = 0;
        `CHK(load_busy_reg, 1'h0)
        param_valid = 1;
        @(negedge clock);
        param_valid = 0;
        `CHK(param_ignored_reg, 1'h1)
        pass(2'h1);
    endtask

    // Hardware reset brings the defaults back
    task automatic t_hw_reset;
        srst = 1;
        repeat (2) @(negedge clock);
        srst = 0;
        foreach (wr[i])
            wr[i] = 0;
        @(negedge clock);
        pass(2'h1);
        pass(2'h2);
    endtask

    // Prints the verdict and stops
    task automatic end_of_test;
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(negedge clock);
        srst = 0;
        @(negedge clock);
        t_defaults();
        t_full_load();
        t_abort();
        t_hw_reset();
        end_of_test();
    end
endmodule
